/* File: logic/crs_core_regs.sv */
// Purpose: programmer-visible register set of the 8-bit core
// Assumes: sequencer, ALU and memory bus share clk_sys_i
// Notes:   one command per cycle; stack lives in a private array
// Behaviour
// - Index bit 11 selects data or program space
// - Space-select bit is write only
// - Index pointer mapped at two byte locations
// - Effective address is pointer plus unsigned offset; data space keeps only its low byte
// - Indexed program-space accesses are reads only
// - Counting uses only lower eleven pointer bits
// - Program counter resets to program start
// - Stack pointer resets to all ones
// - Stack limited to sixteen top RAM bytes
// - Push subtracts two, pull adds two
// - Pointer addresses next free stack byte
// - Call pushes return address, low byte first
// - Return pulls address into program counter
// - Carry from arithmetic and dedicated instructions
// - Rotates shift through the carry flag
// - Half carry captures carry from bit three
// - Zero flag set on zero result
// - Negative flag copies result top bit
// - Mask low keeps maskable requests pending
// - Reset clears mask; only software sets it
// - Mask cleared after stacking and vector fetch
// - Interrupt return restores counter, sets mask
// - Status holds four flags, mask, ready
// - Software interrupt ignores mask, stacks, clears
`include "crs_defs.svh"
`default_nettype none
module crs_core_regs (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  input  wire crs_pkg::crs_cmd_type cmd_i,
  input  wire logic               irq_pend_i,
  input  wire logic               nvm_ready_i,
  input  wire logic               mem_wr_i,
  input  wire logic               mem_rd_i,
  input  wire logic [7:0]         mem_addr_i,
  input  wire logic [7:0]         mem_wdata_i,
  output logic [7:0]              mem_rdata_o,
  output logic                    mem_hit_o,
  output logic [7:0]              acc_o,
  output logic [11:0]             index_o,
  output logic [11:0]             pc_o,
  output logic [3:0]              stack_pointer_o,
  output logic [7:0]              status_flags_o,
  output var crs_pkg::crs_idx_type idx_o,
  output logic                    irq_recog_o
);
  import crs_pkg::*;

  logic [7:0]    acc_r;
  logic [11:0]   index_r;
  logic [11:0]   pc_r;
  logic [3:0]    sp_r;
  logic [7:0]    stack_r [16];
  logic          c_r, h_r, z_r, n_r, g_r;
  crs_state_type state_r;
  logic [7:0]    res_nxt;
  logic          c_nxt, h_nxt, upd_c, upd_h, upd_zn;
  logic [8:0]    sum9;
  logic [4:0]    sum5;
  logic          cin;
  logic          push, pull;
  logic [3:0]    sp_nxt;
  logic [11:0]   pull_addr;
  logic [10:0]   eff_sum;
  logic [7:0]    sr_view;

  assign cin  = cmd_i.use_carry & c_r;
  assign push = cmd_i.op == CRS_OP_SUBROUTINE_CALL ||
                cmd_i.op == CRS_OP_IRQ ||
                cmd_i.op == CRS_OP_SOFTWARE_INTERRUPT;
  assign pull = cmd_i.op == CRS_OP_SUBROUTINE_RETURN ||
                cmd_i.op == CRS_OP_INTERRUPT_RETURN;
  // Return address sits high byte above free slot, low byte above that
  assign pull_addr = {stack_r[4'(sp_r + 4'h1)][3:0],
                      stack_r[4'(sp_r + 4'h2)]};
  assign sr_view = {nvm_ready_i, 2'b00, g_r, z_r, c_r, h_r, n_r};

  // ALU flag generation
  always_comb begin
    res_nxt = acc_r;
    c_nxt   = c_r;
    h_nxt   = h_r;
    upd_c   = 1'b0;
    upd_h   = 1'b0;
    upd_zn  = 1'b0;
    sum9    = 9'h000;
    sum5    = 5'h00;
    case (cmd_i.op)
      CRS_OP_LOAD_ACC: begin
        res_nxt = cmd_i.operand;
        upd_zn  = 1'b1;
      end
      CRS_OP_ADD: begin
        sum9    = {1'b0, acc_r} + {1'b0, cmd_i.operand} + {8'h00, cin};
        sum5    = {1'b0, acc_r[3:0]} + {1'b0, cmd_i.operand[3:0]}
                  + {4'h0, cin};
        res_nxt = sum9[7:0];
        c_nxt   = sum9[8];
        h_nxt   = sum5[4];
        {upd_c, upd_h, upd_zn} = 3'b111;
      end
      CRS_OP_SUB: begin
        // Carry flag here means borrow out of the top bit
        sum9    = {1'b0, acc_r} - {1'b0, cmd_i.operand} - {8'h00, cin};
        sum5    = {1'b0, acc_r[3:0]} - {1'b0, cmd_i.operand[3:0]}
                  - {4'h0, cin};
        res_nxt = sum9[7:0];
        c_nxt   = sum9[8];
        h_nxt   = sum5[4];
        {upd_c, upd_h, upd_zn} = 3'b111;
      end
      CRS_OP_AND: begin
        res_nxt = acc_r & cmd_i.operand;
        upd_zn  = 1'b1;
      end
      CRS_OP_OR: begin
        res_nxt = acc_r | cmd_i.operand;
        upd_zn  = 1'b1;
      end
      CRS_OP_XOR: begin
        res_nxt = acc_r ^ cmd_i.operand;
        upd_zn  = 1'b1;
      end
      CRS_OP_ROL: begin
        res_nxt = {acc_r[6:0], c_r};
        c_nxt   = acc_r[7];
        {upd_c, upd_zn} = 2'b11;
      end
      CRS_OP_ROR: begin
        res_nxt = {c_r, acc_r[7:1]};
        c_nxt   = acc_r[0];
        {upd_c, upd_zn} = 2'b11;
      end
      CRS_OP_SET_C, CRS_OP_CLR_C: begin
        c_nxt = (cmd_i.op == CRS_OP_SET_C);
        upd_c = 1'b1;
      end
      CRS_OP_INVERT_CARRY: begin
        c_nxt = ~c_r;
        upd_c = 1'b1;
      end
      CRS_OP_LOAD_CARRY_FROM_BIT: begin
        c_nxt = cmd_i.operand[cmd_i.bit_sel];
        upd_c = 1'b1;
      end
      default: res_nxt = acc_r;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      acc_r <= 8'h00;
    end else if (upd_zn) begin
      acc_r <= res_nxt;
    end
  end

  // Condition flags; sequencer commands take priority over a mem write
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      {c_r, h_r, z_r, n_r} <= 4'h0;
    end else if (upd_c || upd_h || upd_zn) begin
      if (upd_c) c_r <= c_nxt;
      if (upd_h) h_r <= h_nxt;
      if (upd_zn) begin
        z_r <= (res_nxt == 8'h00);
        n_r <= res_nxt[7];
      end
    end else if (mem_wr_i && mem_addr_i == `CRS_STATUS_OFS) begin
      c_r <= mem_wdata_i[`CRS_SR_C];
      h_r <= mem_wdata_i[`CRS_SR_H];
      z_r <= mem_wdata_i[`CRS_SR_Z];
      n_r <= mem_wdata_i[`CRS_SR_N];
    end
  end

  // Interrupt sequencing: mask drops one cycle after stacking and vector
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= CRS_ST_IDLE;
    end else begin
      case (state_r)
        CRS_ST_IDLE: begin
          if (cmd_i.op == CRS_OP_IRQ ||
              cmd_i.op == CRS_OP_SOFTWARE_INTERRUPT) begin
            state_r <= CRS_ST_VEC;
          end
        end
        CRS_ST_VEC: state_r <= CRS_ST_IDLE;
        default:    state_r <= CRS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      g_r <= 1'b0;
    end else if (cmd_i.op == CRS_OP_SET_G ||
                 cmd_i.op == CRS_OP_INTERRUPT_RETURN) begin
      g_r <= 1'b1;
    end else if (state_r == CRS_ST_VEC ||
                 cmd_i.op == CRS_OP_CLR_G) begin
      g_r <= 1'b0;
    end else if (mem_wr_i && mem_addr_i == `CRS_STATUS_OFS) begin
      g_r <= mem_wdata_i[`CRS_SR_G];
    end
  end

  // Maskable request is only flagged while the mask is set
  always_ff @(posedge clk_sys_i) begin
    irq_recog_o <= ~reset_i & irq_pend_i & g_r &
                   (state_r == CRS_ST_IDLE);
  end

  // Index pointer
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      index_r <= 12'h000;
    end else if (cmd_i.op == CRS_OP_LOAD_X) begin
      index_r <= cmd_i.addr;
    end else if (cmd_i.op == CRS_OP_INC_X) begin
      index_r[10:0] <= index_r[10:0] + 11'h001;
    end else if (cmd_i.op == CRS_OP_DEC_X) begin
      index_r[10:0] <= index_r[10:0] - 11'h001;
    end else if (mem_wr_i && mem_addr_i == `CRS_IDXP_HIGH_OFS) begin
      index_r[11:8] <= mem_wdata_i[3:0];
    end else if (mem_wr_i && mem_addr_i == `CRS_IDXP_LOW_OFS) begin
      index_r[7:0] <= mem_wdata_i;
    end
  end

  // Indexed address generation
  assign eff_sum = index_r[10:0] + {3'b000, cmd_i.operand};
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      idx_o <= '0;
    end else begin
      idx_o.addr <= index_r[11] ? (`CRS_PROG_BASE | {1'b0, eff_sum})
                                : (`CRS_DATA_BASE | {4'h0, eff_sum[7:0]});
      idx_o.rd <= cmd_i.idx_en & ~cmd_i.idx_wr;
      idx_o.wr <= cmd_i.idx_en & cmd_i.idx_wr & ~index_r[11];
    end
  end

  // Stack pointer
  always_comb begin
    sp_nxt = sp_r;
    if (push) begin
      sp_nxt = sp_r - 4'h2;
    end else if (pull) begin
      sp_nxt = sp_r + 4'h2;
    end else if (cmd_i.op == CRS_OP_LOAD_SP) begin
      sp_nxt = cmd_i.operand[3:0];
    end else if (mem_wr_i && mem_addr_i == `CRS_STACK_PTR_OFS) begin
      sp_nxt = mem_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sp_r <= `CRS_SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Stack bytes: 4-bit pointer keeps every slot in the top sixteen bytes
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      stack_r[sp_r]                <= pc_r[7:0];
      stack_r[4'(sp_r - 4'h1)]     <= {4'h0, pc_r[11:8]};
    end
  end

  // Program counter
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pc_r <= `CRS_PC_RESET;
    end else if (push || cmd_i.op == CRS_OP_JUMP) begin
      pc_r <= cmd_i.addr;
    end else if (pull) begin
      pc_r <= pull_addr;
    end else if (cmd_i.op == CRS_OP_STEP) begin
      pc_r <= {pc_r[11], pc_r[10:0] + 11'h001};
    end
  end

  // Memory-mapped read port; unmapped offsets answer zero with no hit
  always_ff @(posedge clk_sys_i) begin
    mem_hit_o   <= 1'b0;
    mem_rdata_o <= 8'h00;
    if (!reset_i && mem_rd_i) begin
      mem_hit_o <= 1'b1;
      case (mem_addr_i)
        `CRS_IDXP_HIGH_OFS: mem_rdata_o <= {5'h00, index_r[10:8]};
        `CRS_IDXP_LOW_OFS:  mem_rdata_o <= index_r[7:0];
        `CRS_STACK_PTR_OFS: mem_rdata_o <= {4'h0, sp_r};
        `CRS_STATUS_OFS:    mem_rdata_o <= sr_view;
        default:            mem_hit_o   <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      acc_o           <= 8'h00;
      index_o         <= 12'h000;
      pc_o            <= `CRS_PC_RESET;
      stack_pointer_o <= `CRS_SP_RESET;
      status_flags_o  <= 8'h00;
    end else begin
      acc_o           <= acc_r;
      index_o         <= index_r;
      pc_o            <= pc_r;
      stack_pointer_o <= sp_r;
      status_flags_o  <= sr_view;
    end
  end

  sequence vec_s;
    (cmd_i.op == CRS_OP_IRQ || cmd_i.op == CRS_OP_SOFTWARE_INTERRUPT)
      && state_r == CRS_ST_IDLE;
  endsequence

  mask_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    vec_s ##1 (cmd_i.op == CRS_OP_NONE) |-> ##1 !g_r)
    else $error("mask not cleared after vector");
  push_step_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    push |=> sp_r == 4'($past(sp_r) - 4'h2))
    else $error("push did not move pointer by two");
  call_return_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cmd_i.op == CRS_OP_SUBROUTINE_CALL) ##1
    (cmd_i.op == CRS_OP_SUBROUTINE_RETURN) |=> pc_r == $past(pc_r, 2))
    else $error("return address mismatch");
  interrupt_return_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd_i.op == CRS_OP_INTERRUPT_RETURN |=> g_r)
    else $error("mask not set by interrupt return");
  prog_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    idx_o.wr |-> idx_o.addr < `CRS_PROG_BASE)
    else $error("write into program space");
  zero_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    upd_zn |=> z_r == (acc_r == 8'h00) && n_r == acc_r[7])
    else $error("zero or negative flag wrong");
  recog_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    irq_recog_o |-> $past(g_r) && $past(irq_pend_i))
    else $error("request recognised while masked");
  high_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mem_rd_i && mem_addr_i == `CRS_IDXP_HIGH_OFS
      |=> mem_rdata_o[7:3] == 5'h00)
    else $error("space bit visible on read");
  rotate_carry_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd_i.op == CRS_OP_ROL |=> c_r == $past(acc_r[7])
      && acc_r[0] == $past(c_r))
    else $error("rotate not through carry");
  reset_vals_a: assert property (@(posedge clk_sys_i)
    reset_i |=> sp_r == `CRS_SP_RESET && pc_r == `CRS_PC_RESET && !g_r)
    else $error("reset values wrong");
endmodule : crs_core_regs
`default_nettype wire

/* File: logic/crs_defs.svh */
// Purpose: constants of the core register set
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_IDXP_HIGH_OFS 8'hBE
`define CRS_IDXP_LOW_OFS  8'hBF
`define CRS_STACK_PTR_OFS 8'hBC
`define CRS_STATUS_OFS    8'hBD
`define CRS_PC_RESET      12'h800
`define CRS_SP_RESET      4'hF
`define CRS_STACK_BASE    8'h30
`define CRS_DATA_BASE     12'h000
`define CRS_PROG_BASE     12'h800
`define CRS_SR_N          0
`define CRS_SR_H          1
`define CRS_SR_C          2
`define CRS_SR_Z          3
`define CRS_SR_G          4
`define CRS_SR_R          7
`define CRS_SR_WMASK      8'h1F
`endif

/* File: logic/crs_pkg.sv */
// Purpose: types of the core register set
// Assumes: nothing
// Notes:   command word from the sequencer
`default_nettype none
package crs_pkg;
  typedef enum logic [4:0] {
    CRS_OP_NONE, CRS_OP_LOAD_ACC, CRS_OP_ADD, CRS_OP_SUB, CRS_OP_AND,
    CRS_OP_OR, CRS_OP_XOR, CRS_OP_ROL, CRS_OP_ROR, CRS_OP_SET_C,
    CRS_OP_CLR_C, CRS_OP_INVERT_CARRY, CRS_OP_LOAD_CARRY_FROM_BIT,
    CRS_OP_LOAD_X, CRS_OP_INC_X, CRS_OP_DEC_X, CRS_OP_LOAD_SP,
    CRS_OP_SUBROUTINE_CALL, CRS_OP_SUBROUTINE_RETURN,
    CRS_OP_INTERRUPT_RETURN, CRS_OP_IRQ, CRS_OP_SOFTWARE_INTERRUPT,
    CRS_OP_SET_G, CRS_OP_CLR_G, CRS_OP_JUMP, CRS_OP_STEP
  } crs_op_type;

  typedef enum logic [1:0] {
    CRS_ST_IDLE = 2'b01,
    CRS_ST_VEC  = 2'b10
  } crs_state_type;

  typedef struct packed {
    crs_op_type  op;
    logic [7:0]  operand;
    logic [2:0]  bit_sel;
    logic        use_carry;
    logic [11:0] addr;
    logic        idx_en;
    logic        idx_wr;
  } crs_cmd_type;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
  } crs_idx_type;
endpackage : crs_pkg
`default_nettype wire

/* File: verification/crs_seq_model.sv */
// Purpose: sequencer and memory-bus stand-in facing the register set
// Assumes: tasks are entered just after a falling edge of clk_sys_i
// Notes:   released bus lines carry inverted junk, not the last value
`default_nettype none
module crs_seq_model (
  input  wire logic                 clk_sys_i,
  input  wire logic [7:0]           mem_rdata_i,
  input  wire logic                 mem_hit_i,
  output var  crs_pkg::crs_cmd_type cmd_o,
  output logic                      mem_wr_o,
  output logic                      mem_rd_o,
  output logic [7:0]                mem_addr_o,
  output logic [7:0]                mem_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;

  initial begin
    cmd_o       = '0;
    mem_wr_o    = 1'b0;
    mem_rd_o    = 1'b0;
    mem_addr_o  = 8'h00;
    mem_wdata_o = 8'h00;
  end

  // A command stays until the next call replaces it
  task automatic go(input crs_cmd_type c);
    cmd_o = c;
    @(negedge clk_sys_i);
  endtask : go

  // Strobe for one edge; registered answer is taken a cycle later
  task automatic mem(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic hit);
    mem_wr_o    = wr;
    mem_rd_o    = !wr;
    mem_addr_o  = a;
    mem_wdata_o = d;
    @(negedge clk_sys_i);
    q           = mem_rdata_i;
    hit         = mem_hit_i;
    mem_wr_o    = 1'b0;
    mem_rd_o    = 1'b0;
    mem_addr_o  = ~a;
    mem_wdata_o = ~d;
    @(negedge clk_sys_i);
  endtask : mem
endmodule : crs_seq_model
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: self-checking bench for the core register set
// Assumes: outputs trail internal state by one cycle
// Notes:   seed 42; corner pairs lead the random arithmetic
`include "crs_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;

  logic        clk_sys_i   = 1'b0;
  logic        reset_i     = 1'b1;
  logic        irq_pend_i  = 1'b0;
  logic        nvm_ready_i = 1'b0;
  crs_cmd_type cmd;
  crs_idx_type idx;
  logic        mem_wr, mem_rd, mem_hit, recog, hit;
  logic [7:0]  mem_addr, mem_wdata, mem_rdata, acc, sr, q;
  logic [11:0] index, pc;
  logic [3:0]  sp;
  int          num_errors   = 0;
  int          total_checks = 0;
  logic [7:0]  ca [4] = '{8'hFF, 8'h0F, 8'h80, 8'h00};
  logic [7:0]  cb [4] = '{8'h01, 8'h01, 8'h80, 8'h00};
  crs_op_type  so [6] = '{CRS_OP_LOAD_SP, CRS_OP_JUMP,
    CRS_OP_SUBROUTINE_CALL, CRS_OP_SUBROUTINE_CALL,
    CRS_OP_SUBROUTINE_RETURN, CRS_OP_SUBROUTINE_RETURN};
  logic [11:0] sa [6] = '{12'h001, 12'h8A5, 12'h900, 12'hA00,
                          12'h000, 12'h000};
  logic [11:0] pe [6] = '{12'h800, 12'h8A5, 12'h900, 12'hA00,
                          12'h900, 12'h8A5};
  logic [3:0]  se [6] = '{4'h1, 4'h1, 4'hF, 4'hD, 4'hF, 4'h1};
  crs_op_type  lo [3] = '{CRS_OP_AND, CRS_OP_OR, CRS_OP_XOR};

  crs_core_regs crs_core_regs_inst (
    .clk_sys_i      (clk_sys_i),
    .reset_i        (reset_i),
    .cmd_i          (cmd),
    .irq_pend_i     (irq_pend_i),
    .nvm_ready_i    (nvm_ready_i),
    .mem_wr_i       (mem_wr),
    .mem_rd_i       (mem_rd),
    .mem_addr_i     (mem_addr),
    .mem_wdata_i    (mem_wdata),
    .mem_rdata_o    (mem_rdata),
    .mem_hit_o      (mem_hit),
    .acc_o          (acc),
    .index_o        (index),
    .pc_o           (pc),
    .stack_pointer_o(sp),
    .status_flags_o (sr),
    .idx_o          (idx),
    .irq_recog_o    (recog)
  );

  crs_seq_model crs_seq_model_inst (
    .clk_sys_i  (clk_sys_i),
    .mem_rdata_i(mem_rdata),
    .mem_hit_i  (mem_hit),
    .cmd_o      (cmd),
    .mem_wr_o   (mem_wr),
    .mem_rd_o   (mem_rd),
    .mem_addr_o (mem_addr),
    .mem_wdata_o(mem_wdata)
  );

  always #2.5 clk_sys_i = ~clk_sys_i;

  function automatic logic [9:0] add_exp(logic [7:0] x, logic [7:0] y);
    logic [8:0] s;
    logic [4:0] hs;
    s       = x + y;
    hs      = x[3:0] + y[3:0];
    add_exp = {s[8], hs[4], s[7:0]};
  endfunction : add_exp

  function automatic logic [7:0] logic_exp(int k, logic [7:0] x,
                                           logic [7:0] y);
    logic_exp = (k == 0) ? (x & y) : (k == 1) ? (x | y) : (x ^ y);
  endfunction : logic_exp

  // Program space keeps eleven bits, data space only the low byte
  function automatic logic [11:0] ea(logic [11:0] x, logic [7:0] o);
    logic [10:0] s;
    s  = x[10:0] + o;
    ea = x[11] ? {1'b1, s} : {4'h0, s[7:0]};
  endfunction : ea

  task automatic do_op(crs_op_type o, logic [7:0] v = 8'h00,
                       logic [11:0] ad = 12'h000, logic [2:0] bs = 3'd0,
                       logic ix = 1'b0, logic iw = 1'b1);
    crs_cmd_type c;
    c         = '0;
    c.op      = o;
    c.operand = v;
    c.addr    = ad;
    c.bit_sel = bs;
    c.idx_en  = ix;
    c.idx_wr  = ix & iw;
    crs_seq_model_inst.go(c);
  endtask : do_op

  task automatic rw(logic wr, logic [7:0] a, logic [7:0] d);
    crs_seq_model_inst.mem(wr, a, d, q, hit);
  endtask : rw

  task automatic chk_reset();
    `CHK("acc", 8'h00, acc)
    `CHK("pc", 12'h800, pc)
    `CHK("sp", 4'hF, sp)
    `CHK("sr", 8'h00, sr)
  endtask : chk_reset

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin : watchdog
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    close_out();
  end

  initial begin : main
    logic [9:0]  e;
    logic [11:0] x;
    logic [7:0]  a, b, r;
    logic        cy;
    crs_cmd_type cc;
    void'($urandom(42));
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    chk_reset();
    for (int i = 0; i < 24; i++) begin
      a = (i < 4) ? ca[i] : 8'($urandom);
      b = (i < 4) ? cb[i] : 8'($urandom);
      e = add_exp(a, b);
      do_op(CRS_OP_LOAD_ACC, a);
      do_op(CRS_OP_ADD, b);
      do_op(CRS_OP_LOAD_ACC, a);
      `CHK("add acc", e[7:0], acc)
      `CHK("add c", e[9], sr[`CRS_SR_C])
      `CHK("add h", e[8], sr[`CRS_SR_H])
      `CHK("add z", e[7:0] == 8'h00, sr[`CRS_SR_Z])
      `CHK("add n", e[7], sr[`CRS_SR_N])
      do_op(CRS_OP_SUB, b);
      do_op(CRS_OP_NONE);
      `CHK("sub acc", 8'(a - b), acc)
      `CHK("sub c", a < b, sr[`CRS_SR_C])
      `CHK("sub z", a == b, sr[`CRS_SR_Z])
      do_op(CRS_OP_LOAD_ACC, a);
      do_op(lo[i % 3], b);
      do_op(CRS_OP_NONE);
      r = logic_exp(i % 3, a, b);
      `CHK("logic acc", r, acc)
      `CHK("logic z", r == 8'h00, sr[`CRS_SR_Z])
      `CHK("logic n", r[7], sr[`CRS_SR_N])
    end
    cc           = '0;
    cc.op        = CRS_OP_ADD;
    cc.operand   = 8'h0F;
    cc.use_carry = 1'b1;
    do_op(CRS_OP_SET_C);
    do_op(CRS_OP_LOAD_ACC, 8'h10);
    crs_seq_model_inst.go(cc);
    do_op(CRS_OP_NONE);
    `CHK("adc acc", 8'h20, acc)
    `CHK("adc c", 1'b0, sr[`CRS_SR_C])
    `CHK("adc h", 1'b1, sr[`CRS_SR_H])
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      do_op(CRS_OP_LOAD_ACC, a);
      do_op(i[0] ? CRS_OP_SET_C : CRS_OP_CLR_C);
      do_op(i[1] ? CRS_OP_ROR : CRS_OP_ROL);
      do_op(CRS_OP_NONE);
      if (i[1]) begin
        {b, cy} = {i[0], a};
      end else begin
        {cy, b} = {a, i[0]};
      end
      `CHK("rot acc", b, acc)
      `CHK("rot c", cy, sr[`CRS_SR_C])
    end
    do_op(CRS_OP_INVERT_CARRY);
    do_op(CRS_OP_LOAD_CARRY_FROM_BIT, cy ? 8'h20 : 8'hDF, 12'h000, 3'd5);
    `CHK("invert_carry", !cy, sr[`CRS_SR_C])
    do_op(CRS_OP_NONE);
    `CHK("ldc", cy, sr[`CRS_SR_C])
    for (int j = 0; j < 2; j++) begin
      x = {j[0], 11'($urandom)};
      b = 8'($urandom);
      do_op(CRS_OP_LOAD_X, 8'h00, x);
      do_op(CRS_OP_NONE, b, 12'h000, 3'd0, 1'b1);
      `CHK("idx addr", ea(x, b), idx.addr)
      `CHK("idx wr", !x[11], idx.wr)
      do_op(CRS_OP_NONE, b, 12'h000, 3'd0, 1'b1, 1'b0);
      `CHK("idx rd", 1'b1, idx.rd)
      `CHK("idx rd wr", 1'b0, idx.wr)
      `CHK("idx rd addr", ea(x, b), idx.addr)
      `CHK("index", x, index)
      rw(1'b0, 8'hBE, 8'h00);
      `CHK("x high", {5'h00, x[10:8]}, q)
      rw(1'b0, 8'hBF, 8'h00);
      `CHK("x low", x[7:0], q)
      `CHK("hit", 1'b1, hit)
    end
    rw(1'b1, 8'hBF, 8'hFF);
    rw(1'b1, 8'hBE, 8'h0F);
    `CHK("x wr", 12'hFFF, index)
    rw(1'b0, 8'hBE, 8'h00);
    `CHK("x bit11", 8'h07, q)
    do_op(CRS_OP_INC_X);
    do_op(CRS_OP_DEC_X);
    `CHK("x inc", 12'h800, index)
    do_op(CRS_OP_NONE);
    `CHK("x dec", 12'hFFF, index)
    rw(1'b0, 8'h40, 8'h00);
    `CHK("unmapped q", 8'h00, q)
    `CHK("unmapped hit", 1'b0, hit)
    nvm_ready_i = 1'b1;
    rw(1'b1, 8'hBD, 8'hFF);
    rw(1'b0, 8'hBD, 8'h00);
    `CHK("sr rd", 8'h9F, q)
    rw(1'b1, 8'hBD, 8'h00);
    `CHK("sr clr", 8'h80, sr)
    for (int i = 0; i < 6; i++) begin
      do_op(so[i], 8'h01, sa[i]);
      do_op(CRS_OP_NONE);
      `CHK("stk pc", pe[i], pc)
      `CHK("stk sp", se[i], sp)
    end
    rw(1'b0, 8'hBC, 8'h00);
    `CHK("sp rd", 8'h01, q)
    irq_pend_i = 1'b1;
    do_op(CRS_OP_NONE);
    do_op(CRS_OP_NONE);
    `CHK("recog off", 1'b0, recog)
    do_op(CRS_OP_SET_G);
    do_op(CRS_OP_NONE);
    `CHK("recog on", 1'b1, recog)
    do_op(CRS_OP_IRQ, 8'h00, 12'hFF0);
    do_op(CRS_OP_NONE);
    `CHK("irq pc", 12'hFF0, pc)
    `CHK("irq sp", 4'hF, sp)
    `CHK("g late", 1'b1, sr[`CRS_SR_G])
    irq_pend_i = 1'b0;
    do_op(CRS_OP_NONE);
    `CHK("g clear", 1'b0, sr[`CRS_SR_G])
    `CHK("recog end", 1'b0, recog)
    do_op(CRS_OP_INTERRUPT_RETURN);
    do_op(CRS_OP_SOFTWARE_INTERRUPT, 8'h00, 12'hFE0);
    `CHK("interrupt_return pc", 12'h8A5, pc)
    `CHK("interrupt_return g", 1'b1, sr[`CRS_SR_G])
    do_op(CRS_OP_NONE);
    do_op(CRS_OP_NONE);
    `CHK("swi pc", 12'hFE0, pc)
    `CHK("swi sp", 4'hF, sp)
    `CHK("swi g", 1'b0, sr[`CRS_SR_G])
    do_op(CRS_OP_SOFTWARE_INTERRUPT, 8'h00, 12'hFD0);
    do_op(CRS_OP_SUBROUTINE_RETURN);
    `CHK("swi2 pc", 12'hFD0, pc)
    do_op(CRS_OP_NONE);
    `CHK("swi2 g", 1'b0, sr[`CRS_SR_G])
    `CHK("ret pc", 12'hFE0, pc)
    do_op(CRS_OP_STEP);
    do_op(CRS_OP_SUBROUTINE_CALL, 8'h00, 12'h9C0);
    `CHK("step pc", 12'hFE1, pc)
    do_op(CRS_OP_SUBROUTINE_RETURN);
    `CHK("call pc", 12'h9C0, pc)
    do_op(CRS_OP_NONE);
    `CHK("back pc", 12'hFE1, pc)
    do_op(CRS_OP_SET_G);
    do_op(CRS_OP_CLR_G);
    `CHK("g set", 1'b1, sr[`CRS_SR_G])
    do_op(CRS_OP_SET_G);
    `CHK("g clr", 1'b0, sr[`CRS_SR_G])
    reset_i = 1'b1;
    do_op(CRS_OP_NONE);
    do_op(CRS_OP_NONE);
    reset_i = 1'b0;
    chk_reset();
    do_op(CRS_OP_NONE);
    `CHK("sr after", 8'h80, sr)
    close_out();
  end
endmodule : testbench
`default_nettype wire
